//--- hw/klmcu_regs.svh
// Purpose: constants for the keys, logic and mode control unit
// Assumes: 16-bit words, keys bit 1 (msb, index 15) is the carry flag
// Notes: field positions use little-endian index, doc bit 1 = index 15
`ifndef KLMCU_REGS_SVH
`define KLMCU_REGS_SVH
`define KLMCU_CARRY_BIT 15
`define KLMCU_MODE_HI 12
`define KLMCU_MODE_LO 10
`define KLMCU_KEYS_RESET 16'h0000
`define KLMCU_IO_DEV_NOTEST 6'h10
`define KLMCU_CC_LT_BIT 7
`define KLMCU_CC_EQ_BIT 6
`define KLMCU_OPC_IO 4'hb
`endif

//--- hw/klmcu_pkg.sv
// Purpose: types for the keys, logic and mode control unit
// Assumes: nothing
// Notes: operation codes are an internal encoding of this block
package klmcu_pkg;
   typedef enum logic [4:0] {
      KLMCU_NOP,
      KLMCU_EXECUTE_IO_INDIRECT,
      KLMCU_INPUT_TO_ACCUMULATOR,
      KLMCU_READ_KEYS_TO_ACC,
      KLMCU_WRITE_KEYS_FROM_ACC,
      KLMCU_SET_CARRY_FLAG,
      KLMCU_CLEAR_CARRY_FLAG,
      KLMCU_TRANSFER_ACC_TO_KEYS,
      KLMCU_TRANSFER_KEYS_TO_ACC,
      KLMCU_XOR_TO_ACCUMULATOR,
      KLMCU_COMPLEMENT_ACCUMULATOR,
      KLMCU_AND_TO_ACCUMULATOR,
      KLMCU_AND_LONG_REGISTER,
      KLMCU_INCLUSIVE_OR_ACCUMULATOR,
      KLMCU_XOR_LONG_REGISTER,
      KLMCU_LOGICIZE,
      KLMCU_LOGIC_SET_TRUE,
      KLMCU_LOGIC_SET_FALSE,
      KLMCU_PAGING_ON_JUMP,
      KLMCU_PAGING_OFF_JUMP,
      KLMCU_RESTRICTED_ON_JUMP,
      KLMCU_VIRTUAL_ON_JUMP,
      KLMCU_PAGING_ON_MICROJUMP
   } klmcu_op_e;
   // Source of a logicize test
   typedef enum logic [1:0] {
      KLMCU_SRC_CC,
      KLMCU_SRC_LONG,
      KLMCU_SRC_FLOAT
   } klmcu_src_e;
   // Relation of a logicize test
   typedef enum logic [2:0] {
      KLMCU_REL_LT,
      KLMCU_REL_LE,
      KLMCU_REL_EQ,
      KLMCU_REL_NE,
      KLMCU_REL_GE,
      KLMCU_REL_GT
   } klmcu_rel_e;
   typedef enum logic [1:0] {
      KLMCU_ST_IDLE,
      KLMCU_ST_IO_WAIT,
      KLMCU_ST_JUMP_ADDR
   } klmcu_state_e;
endpackage

//--- hw/klmcu_io_if.sv
// Purpose: carrier between the unit and its I/O sequencer
// Assumes: one request in flight at a time
// Notes: request held until done pulses
`timescale 1ns/1ps
interface klmcu_io_if;
   logic req;
   logic [3:0] io_function_code;
   logic [5:0] io_device_number;
   logic done;
   logic skip;
   logic [15:0] data;
   modport ctrl (output req, output io_function_code,
      output io_device_number, input done, input skip, input data);
   modport seq (input req, input io_function_code,
      input io_device_number, output done, output skip, output data);
endinterface

//--- hw/klmcu_io_seq.sv
// Purpose: runs one input-to-accumulator against the I/O bus
// Assumes: device ready and data are synchronous to clk
// Notes: done is a one-cycle pulse, outputs registered
`timescale 1ns/1ps
`include "klmcu_regs.svh"
module klmcu_io_seq
   import klmcu_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_sync_n,
   // Unit side
   klmcu_io_if.seq io,
   // Device bus
   input wire logic dev_ready,
   input wire logic [15:0] dev_data
);
   logic done_q;
   logic skip_q;
   logic [15:0] data_q;
   logic notest;

   // Device '20 is answered with no ready test and no skip
   assign notest = (io.io_device_number == `KLMCU_IO_DEV_NOTEST);

   // One attempt per request; not-ready finishes without transfer
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         done_q <= 1'b0;
         skip_q <= 1'b0;
         data_q <= 16'h0000;
      end
      else
      begin
         done_q <= io.req && !done_q;
         if (io.req && !done_q)
         begin
            skip_q <= dev_ready && !notest;
            if (dev_ready || notest)
               data_q <= dev_data;
         end
      end
   end

   assign io.done = done_q;
   assign io.skip = skip_q;
   assign io.data = data_q;

   property p_io_single;
      @(posedge clk) disable iff (!rst_sync_n)
      done_q |=> !done_q;
   endproperty
   a_io_single: assert property (p_io_single)
      else $error("io done lasted more than one cycle");
endmodule

//--- hw/klmcu_core.sv
// Purpose: keys, logical operations, logicize and mode control jumps
// Assumes: sequencer issues one op per start pulse, holds operands
// Notes: results and modes come straight out of flip-flops
//
// Summary of operation
// - Indirect I/O runs the effective address word plus index as I/O instruction
// - Read keys copies all of the keys into the accumulator
// - Write keys loads keys from accumulator bit for bit
// - Set carry forces carry to one, other keys kept
// - Clear carry forces carry to zero, other keys kept
// - New addressing mode from transfer applies from next instruction
// - Keys to accumulator places the full keys in accumulator
// - Xor to accumulator with 16-bit memory operand
// - Complement inverts every accumulator bit
// - And to accumulator with 16-bit memory operand
// - Long and of 32-bit long register with memory operand
// - Inclusive or of accumulator with 16-bit memory operand
// - Long xor of 32-bit long register with memory operand
// - Logicize writes one if the zero test holds, else zero
// - Condition-code less is true only for less set, equal clear
// - Logic true writes one, logic false writes zero
// - Paging on jump loads PC, clears associative memory, pages
// - Paging off jump loads PC and disables paging
// - Restricted on jump loads PC, enables restricted and interrupts
// - Virtual on jump combines paging and restricted jumps
// - Paging microjump enables paging, continues at microcode address
// - Input to accumulator tests ready except device '20, skips
`timescale 1ns/1ps
`include "klmcu_regs.svh"
module klmcu_core
   import klmcu_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Operation request
   input wire logic op_start,
   input wire klmcu_op_e op_code,
   input wire klmcu_src_e test_src,
   input wire klmcu_rel_e test_rel,
   input wire logic [15:0] index_x,
   input wire logic [15:0] op_ea,
   // Operands
   input wire logic [15:0] acc_in,
   input wire logic [31:0] long_in,
   input wire logic [31:0] mem_operand,
   input wire logic [15:0] cond_code,
   input wire logic [31:0] float_in,
   input wire logic [15:0] addr_word,
   input wire logic addr_valid,
   input wire logic instr_boundary,
   // I/O bus
   input wire logic dev_ready,
   input wire logic [15:0] dev_data,
   // Results
   output logic [15:0] acc_out,
   output logic acc_we,
   output logic [31:0] long_out,
   output logic long_we,
   output logic [15:0] keys_out,
   output logic [2:0] addr_mode,
   output logic [15:0] pc_out,
   output logic pc_we,
   output logic [15:0] ucode_addr,
   output logic ucode_we,
   output logic skip_next,
   output logic op_done,
   output logic [3:0] io_function_code,
   output logic [5:0] io_device_number,
   // Machine modes
   output logic paging_en,
   output logic restricted_en,
   output logic intr_en,
   output logic assoc_clear
);
   logic [1:0] rst_sync_q;
   logic rst_sync_n;
   klmcu_state_e state_q;
   klmcu_op_e pend_op_q;
   logic [15:0] keys_q;
   logic [2:0] mode_pend_q;
   logic mode_chg_q;
   logic [15:0] acc_q;
   logic acc_we_q;
   logic [31:0] long_q;
   logic long_we_q;
   logic [15:0] pc_q;
   logic pc_we_q;
   logic [15:0] uc_q;
   logic uc_we_q;
   logic skip_q;
   logic done_q;
   logic [2:0] mode_q;
   logic paging_q;
   logic restr_q;
   logic intr_q;
   logic assoc_q;
   logic io_req_q;
   logic [3:0] io_fn_q;
   logic [5:0] io_dev_q;
   logic [15:0] io_word;
   logic io_is_ina;
   logic test_true;

   klmcu_io_if io ();

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_sync_n = rst_sync_q[1];

   // Zero test of a signed value, shared by the condition-code, long and float sources
   function automatic logic rel_test(input klmcu_rel_e rel,
      input logic neg, input logic zero);
      begin
         case (rel)
            KLMCU_REL_LT: rel_test = neg;
            KLMCU_REL_LE: rel_test = neg || zero;
            KLMCU_REL_EQ: rel_test = zero;
            KLMCU_REL_NE: rel_test = !zero;
            KLMCU_REL_GE: rel_test = !neg;
            default: rel_test = !neg && !zero;
         endcase
      end
   endfunction

   // Pick the test source; condition-code less excludes equal
   always_comb
   begin
      logic lt_f;
      logic eq_f;
      lt_f = cond_code[`KLMCU_CC_LT_BIT];
      eq_f = cond_code[`KLMCU_CC_EQ_BIT];
      case (test_src)
         KLMCU_SRC_CC: test_true = rel_test(test_rel,
            lt_f && !eq_f, eq_f);
         KLMCU_SRC_LONG: test_true = rel_test(test_rel,
            long_in[31], long_in == 32'h00000000);
         default: test_true = rel_test(test_rel,
            float_in[31], float_in == 32'h00000000);
      endcase
   end

   // Effective address word plus index forms the I/O instruction
   assign io_word = op_ea + index_x;
   assign io_is_ina = (io_word[15:12] == `KLMCU_OPC_IO);

   assign io.req = io_req_q;
   assign io.io_function_code = io_fn_q;
   assign io.io_device_number = io_dev_q;

   klmcu_io_seq u_io_seq (
      .clk(clk),
      .rst_sync_n(rst_sync_n),
      .io(io.seq),
      .dev_ready(dev_ready),
      .dev_data(dev_data)
   );

   // Sequencing: idle, wait for I/O, wait for jump address word
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_q <= KLMCU_ST_IDLE;
         pend_op_q <= KLMCU_NOP;
         io_req_q <= 1'b0;
         io_fn_q <= 4'h0;
         io_dev_q <= 6'h00;
      end
      else
      begin
         case (state_q)
            KLMCU_ST_IDLE:
               if (op_start)
               begin
                  pend_op_q <= op_code;
                  if (op_code == KLMCU_EXECUTE_IO_INDIRECT && io_is_ina)
                  begin
                     io_fn_q <= io_word[9:6];
                     io_dev_q <= io_word[5:0];
                     io_req_q <= 1'b1;
                     state_q <= KLMCU_ST_IO_WAIT;
                  end
                  else if (op_code == KLMCU_INPUT_TO_ACCUMULATOR)
                  begin
                     io_fn_q <= op_ea[9:6];
                     io_dev_q <= op_ea[5:0];
                     io_req_q <= 1'b1;
                     state_q <= KLMCU_ST_IO_WAIT;
                  end
                  else if (op_code >= KLMCU_PAGING_ON_JUMP)
                     state_q <= KLMCU_ST_JUMP_ADDR;
               end
            KLMCU_ST_IO_WAIT:
               if (io.done)
               begin
                  io_req_q <= 1'b0;
                  state_q <= KLMCU_ST_IDLE;
               end
            default:
               if (addr_valid)
                  state_q <= KLMCU_ST_IDLE;
         endcase
      end
   end

   // Accumulator results
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         acc_q <= 16'h0000;
         acc_we_q <= 1'b0;
      end
      else
      begin
         acc_we_q <= 1'b0;
         if (state_q == KLMCU_ST_IO_WAIT && io.done)
         begin
            acc_q <= io.data;
            acc_we_q <= io.skip || io_dev_q == `KLMCU_IO_DEV_NOTEST;
         end
         else if (state_q == KLMCU_ST_IDLE && op_start)
         begin
            acc_we_q <= 1'b1;
            case (op_code)
               KLMCU_READ_KEYS_TO_ACC: acc_q <= keys_q;
               KLMCU_TRANSFER_KEYS_TO_ACC: acc_q <= keys_q;
               KLMCU_XOR_TO_ACCUMULATOR:
                  acc_q <= acc_in ^ mem_operand[15:0];
               KLMCU_COMPLEMENT_ACCUMULATOR: acc_q <= ~acc_in;
               KLMCU_AND_TO_ACCUMULATOR:
                  acc_q <= acc_in & mem_operand[15:0];
               KLMCU_INCLUSIVE_OR_ACCUMULATOR:
                  acc_q <= acc_in | mem_operand[15:0];
               KLMCU_LOGICIZE:
                  acc_q <= {15'h0000, test_true};
               KLMCU_LOGIC_SET_TRUE: acc_q <= 16'h0001;
               KLMCU_LOGIC_SET_FALSE: acc_q <= 16'h0000;
               default: acc_we_q <= 1'b0;
            endcase
         end
      end
   end

   // Long register results
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         long_q <= 32'h00000000;
         long_we_q <= 1'b0;
      end
      else
      begin
         long_we_q <= 1'b0;
         if (state_q == KLMCU_ST_IDLE && op_start)
         begin
            if (op_code == KLMCU_AND_LONG_REGISTER)
            begin
               long_q <= long_in & mem_operand;
               long_we_q <= 1'b1;
            end
            else if (op_code == KLMCU_XOR_LONG_REGISTER)
            begin
               long_q <= long_in ^ mem_operand;
               long_we_q <= 1'b1;
            end
         end
      end
   end

   // Keys; a mode change is held back until the instruction boundary
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         keys_q <= `KLMCU_KEYS_RESET;
         mode_q <= 3'h0;
         mode_pend_q <= 3'h0;
         mode_chg_q <= 1'b0;
      end
      else
      begin
         if (mode_chg_q && instr_boundary)
         begin
            mode_q <= mode_pend_q;
            mode_chg_q <= 1'b0;
         end
         if (state_q == KLMCU_ST_IDLE && op_start)
         begin
            case (op_code)
               KLMCU_WRITE_KEYS_FROM_ACC, KLMCU_TRANSFER_ACC_TO_KEYS:
               begin
                  keys_q <= acc_in;
                  mode_pend_q <= acc_in[`KLMCU_MODE_HI:`KLMCU_MODE_LO];
                  mode_chg_q <= 1'b1;
               end
               KLMCU_SET_CARRY_FLAG:
                  keys_q[`KLMCU_CARRY_BIT] <= 1'b1;
               KLMCU_CLEAR_CARRY_FLAG:
                  keys_q[`KLMCU_CARRY_BIT] <= 1'b0;
               default: keys_q <= keys_q;
            endcase
         end
      end
   end

   // Jump completion once the address word arrives
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         pc_q <= 16'h0000;
         pc_we_q <= 1'b0;
         uc_q <= 16'h0000;
         uc_we_q <= 1'b0;
         paging_q <= 1'b0;
         restr_q <= 1'b0;
         intr_q <= 1'b0;
         assoc_q <= 1'b0;
      end
      else
      begin
         pc_we_q <= 1'b0;
         uc_we_q <= 1'b0;
         assoc_q <= 1'b0;
         if (state_q == KLMCU_ST_JUMP_ADDR && addr_valid)
         begin
            case (pend_op_q)
               KLMCU_PAGING_ON_JUMP:
               begin
                  pc_q <= addr_word;
                  pc_we_q <= 1'b1;
                  assoc_q <= 1'b1;
                  paging_q <= 1'b1;
               end
               KLMCU_PAGING_OFF_JUMP:
               begin
                  pc_q <= addr_word;
                  pc_we_q <= 1'b1;
                  paging_q <= 1'b0;
               end
               KLMCU_RESTRICTED_ON_JUMP:
               begin
                  pc_q <= addr_word;
                  pc_we_q <= 1'b1;
                  restr_q <= 1'b1;
                  intr_q <= 1'b1;
               end
               KLMCU_VIRTUAL_ON_JUMP:
               begin
                  pc_q <= addr_word;
                  pc_we_q <= 1'b1;
                  assoc_q <= 1'b1;
                  paging_q <= 1'b1;
                  restr_q <= 1'b1;
                  intr_q <= 1'b1;
               end
               default:
               begin
                  uc_q <= addr_word;
                  uc_we_q <= 1'b1;
                  paging_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // Completion pulse and skip indication
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         done_q <= 1'b0;
         skip_q <= 1'b0;
      end
      else
      begin
         skip_q <= state_q == KLMCU_ST_IO_WAIT && io.done
            && io.skip;
         done_q <= (state_q == KLMCU_ST_IO_WAIT && io.done)
            || (state_q == KLMCU_ST_JUMP_ADDR && addr_valid)
            || (state_q == KLMCU_ST_IDLE && op_start
            && op_code != KLMCU_INPUT_TO_ACCUMULATOR
            && !(op_code == KLMCU_EXECUTE_IO_INDIRECT && io_is_ina)
            && op_code < KLMCU_PAGING_ON_JUMP);
      end
   end

   assign acc_out = acc_q;
   assign acc_we = acc_we_q;
   assign long_out = long_q;
   assign long_we = long_we_q;
   assign keys_out = keys_q;
   assign addr_mode = mode_q;
   assign pc_out = pc_q;
   assign pc_we = pc_we_q;
   assign ucode_addr = uc_q;
   assign ucode_we = uc_we_q;
   assign skip_next = skip_q;
   assign op_done = done_q;
   assign io_function_code = io_fn_q;
   assign io_device_number = io_dev_q;
   assign paging_en = paging_q;
   assign restricted_en = restr_q;
   assign intr_en = intr_q;
   assign assoc_clear = assoc_q;

   property p_mode_deferred;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_IDLE && op_start
         && op_code == KLMCU_TRANSFER_ACC_TO_KEYS)
         |=> $stable(mode_q);
   endproperty
   a_mode_deferred: assert property (p_mode_deferred)
      else $error("addressing mode changed in the same instruction");

   property p_carry_set;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_IDLE && op_start
         && op_code == KLMCU_SET_CARRY_FLAG)
         |=> keys_q[`KLMCU_CARRY_BIT]
         && keys_q[14:0] == $past(keys_q[14:0]);
   endproperty
   a_carry_set: assert property (p_carry_set)
      else $error("set carry wrong");

   property p_carry_clr;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_IDLE && op_start
         && op_code == KLMCU_CLEAR_CARRY_FLAG)
         |=> !keys_q[`KLMCU_CARRY_BIT]
         && keys_q[14:0] == $past(keys_q[14:0]);
   endproperty
   a_carry_clr: assert property (p_carry_clr)
      else $error("clear carry wrong");

   property p_xor_acc;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_IDLE && op_start
         && op_code == KLMCU_XOR_TO_ACCUMULATOR)
         |=> acc_we && acc_out == ($past(acc_in) ^ $past(mem_operand[15:0]));
   endproperty
   a_xor_acc: assert property (p_xor_acc)
      else $error("xor to accumulator wrong");

   property p_and_long;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_IDLE && op_start
         && op_code == KLMCU_AND_LONG_REGISTER)
         |=> long_we && long_out == ($past(long_in) & $past(mem_operand));
   endproperty
   a_and_long: assert property (p_and_long)
      else $error("long and wrong");

   property p_logicize_bool;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_IDLE && op_start && op_code == KLMCU_LOGICIZE)
         |=> acc_we && acc_out[15:1] == 15'h0000;
   endproperty
   a_logicize_bool: assert property (p_logicize_bool)
      else $error("logicize result not zero or one");

   property p_virtual_jump;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_JUMP_ADDR && addr_valid
         && pend_op_q == KLMCU_VIRTUAL_ON_JUMP)
         |=> pc_we && assoc_clear && paging_en && restricted_en && intr_en
         && pc_out == $past(addr_word);
   endproperty
   a_virtual_jump: assert property (p_virtual_jump)
      else $error("virtual jump effects missing");

   property p_jump_waits;
      @(posedge clk) disable iff (!rst_sync_n)
      (state_q == KLMCU_ST_JUMP_ADDR && !addr_valid)
         |=> $stable(paging_en) && !pc_we;
   endproperty
   a_jump_waits: assert property (p_jump_waits)
      else $error("mode changed before address word");
endmodule

//--- verif/klmcu_dev_model.sv
// Purpose: far-side device on the I/O bus of the unit
// Assumes: ready and data are levels, synchronous to clk
// Notes: a not-ready device shows a running pattern, never old data
`timescale 1ns/1ps
module klmcu_dev_model
(
   // Clock
   input wire logic clk,
   // Bench control
   input wire logic cfg_ready,
   input wire logic [15:0] cfg_word,
   // Device bus
   output logic dev_ready,
   output logic [15:0] dev_data
);
   logic [15:0] cnt_q = 16'h0;

   // Pattern changes every cycle so a stale read cannot match
   always @(posedge clk)
      cnt_q <= cnt_q + 16'h1;

   // Ready as the bench set it; data as set only while ready, else the count
   assign dev_ready = cfg_ready;
   assign dev_data = cfg_ready ? cfg_word : cnt_q;
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the keys, logic and mode unit
// Assumes: one operation at a time, inputs driven at the rising edge
// Notes: expected values come from the bench's own tables
`timescale 1ns/1ps
module tb
   import klmcu_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_start = 1'b0, addr_valid = 1'b0, instr_boundary = 1'b0;
   klmcu_op_e op_code = KLMCU_NOP;
   klmcu_src_e test_src = KLMCU_SRC_CC;
   klmcu_rel_e test_rel = KLMCU_REL_LT;
   logic [15:0] index_x = 16'h0, op_ea = 16'h0, acc_in = 16'h0;
   logic [15:0] cond_code = 16'h0, addr_word = 16'h0, cfg_word = 16'h0;
   logic [31:0] long_in = 32'h0, mem_operand = 32'h0, float_in = 32'h0;
   logic cfg_ready = 1'b0;
   logic dev_ready;
   logic [15:0] dev_data, acc_out, keys_out, pc_out, ucode_addr;
   logic [31:0] long_out;
   logic [2:0] addr_mode;
   logic [3:0] io_function_code;
   logic [5:0] io_device_number;
   logic acc_we, long_we, pc_we, ucode_we, skip_next, op_done;
   logic paging_en, restricted_en, intr_en, assoc_clear;
   logic [31:0] vals [4] = '{32'hc000_0000, 32'h0, 32'h1, 32'hffff_ffff};
   klmcu_op_e jc [6] = '{KLMCU_PAGING_ON_JUMP, KLMCU_PAGING_OFF_JUMP,
      KLMCU_RESTRICTED_ON_JUMP, KLMCU_VIRTUAL_ON_JUMP,
      KLMCU_PAGING_OFF_JUMP, KLMCU_PAGING_ON_MICROJUMP};
   logic [3:0] jm [6] = '{4'h9, 4'h0, 4'h6, 4'hf, 4'h6, 4'he};
   int fail_count = 0;
   int comparisons = 0;

   klmcu_core i_dut (
      .clk(clk), .rst_n(rst_n), .op_start(op_start), .op_code(op_code),
      .test_src(test_src), .test_rel(test_rel), .index_x(index_x),
      .op_ea(op_ea), .acc_in(acc_in), .long_in(long_in),
      .mem_operand(mem_operand), .cond_code(cond_code),
      .float_in(float_in), .addr_word(addr_word), .addr_valid(addr_valid),
      .instr_boundary(instr_boundary), .dev_ready(dev_ready),
      .dev_data(dev_data), .acc_out(acc_out), .acc_we(acc_we),
      .long_out(long_out), .long_we(long_we), .keys_out(keys_out),
      .addr_mode(addr_mode), .pc_out(pc_out), .pc_we(pc_we),
      .ucode_addr(ucode_addr), .ucode_we(ucode_we), .skip_next(skip_next),
      .op_done(op_done), .io_function_code(io_function_code),
      .io_device_number(io_device_number), .paging_en(paging_en),
      .restricted_en(restricted_en), .intr_en(intr_en),
      .assoc_clear(assoc_clear));

   klmcu_dev_model i_dev (.clk(clk), .cfg_ready(cfg_ready),
      .cfg_word(cfg_word), .dev_ready(dev_ready), .dev_data(dev_data));

   // 50 MHz clock
   always #10 clk = ~clk;

   task chk(input logic [63:0] got, input logic [63:0] exp);
   begin
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   task print_verdict;
   begin
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask

   task tick;
   begin
      @(posedge clk);
      #1;
   end
   endtask

   // One op; gap above zero delays the jump address word gap+1 cycles
   task run(input klmcu_op_e c, input int gap);
      int n;
      logic [2:0] m;
   begin
      @(posedge clk);
      op_code <= c;
      op_start <= 1'b1;
      @(posedge clk);
      op_start <= 1'b0;
      if (gap > 0)
      begin
         m = {paging_en, restricted_en, intr_en};
         repeat (gap) @(posedge clk);
         #1 chk({m, 2'b00}, {paging_en, restricted_en, intr_en, pc_we,
            op_done});
         @(posedge clk);
         addr_valid <= 1'b1;
         @(posedge clk);
         addr_valid <= 1'b0;
      end
      n = 0;
      #1;
      while (op_done !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk(op_done, 1'b1);
   end
   endtask

   // Boundary pulse, then time for the pending mode to land
   task boundary;
   begin
      @(posedge clk);
      instr_boundary <= 1'b1;
      @(posedge clk);
      instr_boundary <= 1'b0;
      repeat (2) tick();
   end
   endtask

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      #1 chk({keys_out, pc_out, acc_we, op_done, paging_en}, 35'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      acc_in <= 16'hc3a5;
      long_in <= 32'h1234_f0f0;
      mem_operand <= 32'hff00_0ff0;
      run(KLMCU_XOR_TO_ACCUMULATOR, 0);
      chk({acc_we, acc_out}, {1'b1, 16'hcc55});
      run(KLMCU_AND_TO_ACCUMULATOR, 0);
      chk({acc_we, acc_out}, {1'b1, 16'h03a0});
      run(KLMCU_INCLUSIVE_OR_ACCUMULATOR, 0);
      chk({acc_we, acc_out}, {1'b1, 16'hcff5});
      run(KLMCU_COMPLEMENT_ACCUMULATOR, 0);
      chk({acc_we, acc_out}, {1'b1, 16'h3c5a});
      run(KLMCU_AND_LONG_REGISTER, 0);
      chk({long_we, long_out}, {1'b1, 32'h1200_00f0});
      run(KLMCU_XOR_LONG_REGISTER, 0);
      chk({long_we, long_out}, {1'b1, 32'hed34_ff00});
      acc_in <= 16'h8000;
      run(KLMCU_WRITE_KEYS_FROM_ACC, 0);
      tick();
      chk(keys_out, 16'h8000);
      run(KLMCU_CLEAR_CARRY_FLAG, 0);
      tick();
      chk(keys_out, 16'h0);
      acc_in <= 16'h5c33;
      run(KLMCU_WRITE_KEYS_FROM_ACC, 0);
      run(KLMCU_SET_CARRY_FLAG, 0);
      tick();
      chk(keys_out, 16'hdc33);
      run(KLMCU_READ_KEYS_TO_ACC, 0);
      chk({acc_we, acc_out}, {1'b1, 16'hdc33});
      run(KLMCU_CLEAR_CARRY_FLAG, 0);
      run(KLMCU_TRANSFER_KEYS_TO_ACC, 0);
      chk({acc_we, acc_out}, {1'b1, 16'h5c33});
      boundary();
      chk(addr_mode, 3'h7);
      acc_in <= 16'h0400;
      run(KLMCU_TRANSFER_ACC_TO_KEYS, 0);
      tick();
      chk({keys_out, addr_mode}, {16'h0400, 3'h7});
      boundary();
      chk(addr_mode, 3'h1);
      // Every source, relation and sign case of the zero test
      for (int s = 0; s < 3; s++)
         for (int v = 0; v < 4; v++)
            for (int r = 0; r < 6; r++)
            begin
               logic [1:0] cc;
               logic ng, zr, ex;
               cc = {v == 0 || v == 3, v == 1 || v == 3};
               ng = (s == 0) ? cc[1] & ~cc[0] : vals[v][31];
               zr = (s == 0) ? cc[0] : vals[v] == 32'h0;
               ex = r == 0 ? ng : r == 1 ? ng | zr : r == 2 ? zr :
                  r == 3 ? ~zr : r == 4 ? ~ng : ~ng & ~zr;
               test_src <= klmcu_src_e'(s);
               test_rel <= klmcu_rel_e'(r);
               cond_code <= {8'h0, cc, 6'h0};
               long_in <= vals[v];
               float_in <= vals[v];
               run(KLMCU_LOGICIZE, 0);
               chk({acc_we, acc_out}, {1'b1, 15'h0, ex});
            end
      run(KLMCU_LOGIC_SET_TRUE, 0);
      chk({acc_we, acc_out}, {1'b1, 16'h1});
      run(KLMCU_LOGIC_SET_FALSE, 0);
      chk({acc_we, acc_out}, {1'b1, 16'h0});
      cfg_ready <= 1'b1;
      cfg_word <= 16'h9b4e;
      index_x <= 16'h4;
      op_ea <= 16'hb200;
      run(KLMCU_EXECUTE_IO_INDIRECT, 0);
      chk({acc_we, skip_next, acc_out}, {2'b11, 16'h9b4e});
      chk({io_function_code, io_device_number}, 10'h204);
      op_ea <= 16'h0104;
      run(KLMCU_INPUT_TO_ACCUMULATOR, 0);
      chk({acc_we, skip_next, io_device_number}, 8'hc4);
      op_ea <= 16'hb200;
      cfg_ready <= 1'b0;
      run(KLMCU_EXECUTE_IO_INDIRECT, 0);
      chk({acc_we, skip_next}, 2'b00);
      op_ea <= 16'hb20c;
      run(KLMCU_EXECUTE_IO_INDIRECT, 0);
      chk({acc_we, skip_next, io_device_number}, 8'h90);
      op_ea <= 16'h1200;
      run(KLMCU_EXECUTE_IO_INDIRECT, 0);
      chk({acc_we, skip_next}, 2'b00);
      // Machine-control jumps in a mode-changing order
      for (int j = 0; j < 6; j++)
      begin
         addr_word <= {12'h100, 4'(j)};
         run(jc[j], 3);
         chk({paging_en, restricted_en, intr_en, assoc_clear},
            jm[j]);
         if (j < 5)
            chk({pc_we, pc_out}, {5'h11, 8'h00, 4'(j)});
         else
            chk({ucode_we, ucode_addr}, {5'h11, 12'h005});
      end
      print_verdict();
   end

   // Watchdog well beyond the few hundred cycles the tests take
   initial
   begin
      #200000;
      fail_count++;
      print_verdict();
   end
endmodule
